// ==== hdl/vcia_pkg.sv ====
// Function
// R01: holding the active-low reset pin low puts the controller into reset.
// R02: reset restores defaults; no request is raised until software enables the controller.
// R03: host configures counters before enabling their outputs (outside this block).
// R04: an unmasked request asserts the active-low request output and prepares a vector.
// R05: low four vector bits carry the acknowledged position number.
// R06: CPU runs one acknowledge cycle for master, two for cascaded requests.
// R07: master acknowledge cycle reads the vector byte driven on the data bus.
// R08: a return cycle ends service so remaining pending requests are re-prioritised.
// R09: single-controller software keeps vector base top bit clear.
// R10: a cascaded source is flagged by a negative byte, top bit set.
// R11: up to sixteen cascaded controllers, 256 sources in total.
// R12: position zero of the master should stay uncascaded.
// R13: decoded select needs low five or six address bits zero.
// R14: external select decoding includes address bit eight.
// R15: software-written list marks which positions are cascaded.
// R16: each position has a 4-bit in-service counter for its cascaded controller.
// R17: a winning cascaded input gives a negative cascade index when acknowledged.
// R18: a cascaded controller gives one distinct unsigned vector per position.
// R19: master return cycle returns the cascade index of the position in service.
// R20: a return cycle at a cascaded controller ends service; its byte is ignored.
// R21: in 8-bit mode the controller answers only with address bit zero low.
// R22: acknowledge clears the winner's pending bit and sets its in-service bit.
// R23: fixed mode acknowledge of a cascaded position increments its counter.
// R24: in-service bit stays set until return and counter back at zero.
// R25: fixed mode: cascaded in-service bit does not block same-priority request.
// R26: data bus is driven only in selected acknowledge or return cycles.
package vcia_pkg;
   localparam int NPOS = 16;
   localparam int AXI_AW = 5;

   localparam logic [AXI_AW-1:0] OFS_CTRL = 5'h00;
   localparam logic [AXI_AW-1:0] OFS_VBASE = 5'h04;
   localparam logic [AXI_AW-1:0] OFS_CASC = 5'h08;
   localparam logic [AXI_AW-1:0] OFS_MASK = 5'h0C;
   localparam logic [AXI_AW-1:0] OFS_PEND = 5'h10;
   localparam logic [AXI_AW-1:0] OFS_IN_SERVICE_BITS = 5'h14;
   localparam logic [AXI_AW-1:0] OFS_STAT = 5'h18;

   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_FIXED_BIT = 1;
   localparam int CTRL_BUS8_BIT = 2;

   localparam logic [2:0] RST_CTRL = 3'h0;
   localparam logic [7:0] RST_VBASE = 8'h00;
   localparam logic [15:0] RST_CASC = 16'h0000;
   localparam logic [15:0] RST_MASK = 16'hFFFF;
   localparam logic [15:0] RST_PEND = 16'h0000;

   localparam logic [3:0] CASC_IDX_HI = 4'hF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int SYNC_STAGES = 2;

   // system bus pins, all active low except address bit zero
   typedef struct packed {
      logic sel_n;
      logic rd_n;
      logic ack_n;
      logic ret_n;
      logic address_bit_zero;
   } vcia_sbus_t;

   typedef struct packed {
      logic bus8;
      logic fixed;
      logic en;
   } vcia_ctrl_t;
endpackage : vcia_pkg

// ==== hdl/vcia_sync.sv ====
`timescale 1ns/1ps
module vcia_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         meta_q <= INIT;
         sync_q <= INIT;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule : vcia_sync

// ==== hdl/vcia_top.sv ====
`timescale 1ns/1ps
module vcia_top #(
   parameter int NPOS = vcia_pkg::NPOS
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_rst_pin_n,
   input wire logic [NPOS-1:0] i_irq,
   input wire vcia_pkg::vcia_sbus_t i_sbus,
   output logic o_int_n,
   output logic [7:0] o_sb_data,
   output logic o_sb_data_oe_n,
   input wire logic [vcia_pkg::AXI_AW-1:0] i_axi_awaddr,
   input wire logic i_axi_awvalid,
   output logic o_axi_awready,
   input wire logic [31:0] i_axi_wdata,
   input wire logic [3:0] i_axi_wstrb,
   input wire logic i_axi_wvalid,
   output logic o_axi_wready,
   output logic [1:0] o_axi_bresp,
   output logic o_axi_bvalid,
   input wire logic i_axi_bready,
   input wire logic [vcia_pkg::AXI_AW-1:0] i_axi_araddr,
   input wire logic i_axi_arvalid,
   output logic o_axi_arready,
   output logic [31:0] o_axi_rdata,
   output logic [1:0] o_axi_rresp,
   output logic o_axi_rvalid,
   input wire logic i_axi_rready
);
   localparam int SW = NPOS + 6;
   localparam logic [SW-1:0] SYNC_INIT = {1'b0, {NPOS{1'b0}}, 5'h1F};

   logic [SW-1:0] sync_out;
   logic rst_pin_n_s;
   logic [NPOS-1:0] irq_s;
   vcia_pkg::vcia_sbus_t sb_s;
   logic rst_all;

   vcia_pkg::vcia_ctrl_t ctrl_q;
   logic [7:0] vbase_q;
   logic [NPOS-1:0] cascade_source_list_q;
   logic [NPOS-1:0] mask_q;
   logic [NPOS-1:0] pending_bits_q;
   logic [NPOS-1:0] pending_bits_d;
   logic [NPOS-1:0] in_service_bits_q;
   logic [NPOS-1:0] in_service_bits_d;
   logic [3:0] isc_cnt_q [NPOS];
   logic [3:0] last_ack_q;

   logic cyc_act;
   logic cyc_prev_q;
   logic ack_start;
   logic ret_start;
   logic win_vld;
   logic [3:0] win_pos;
   logic ret_vld;
   logic [3:0] ret_pos;
   logic [NPOS-1:0] blocked;
   logic [7:0] ack_byte;
   logic [7:0] ret_byte;
   logic ret_keep;

   logic aw_ready_q;
   logic w_ready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic ar_ready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic wr_fire;
   logic o_int_n_q;
   logic [7:0] sb_data_q;
   logic sb_oe_n_q;

   // pins cross into the clock domain before anything looks at them
   vcia_sync #(
      .WIDTH(SW),
      .INIT(SYNC_INIT)
   ) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_async({i_rst_pin_n, i_irq, i_sbus}),
      .o_sync(sync_out)
   );

   assign rst_pin_n_s = sync_out[SW-1];
   assign irq_s = sync_out[SW-2:5];
   assign sb_s = vcia_pkg::vcia_sbus_t'(sync_out[4:0]);
   assign rst_all = i_reset | ~rst_pin_n_s; // [R01]

   // selected acknowledge or return read; odd addresses ignored in 8-bit mode
   assign cyc_act = ~sb_s.sel_n & ~sb_s.rd_n & (~sb_s.ack_n | ~sb_s.ret_n)
                    & ~(ctrl_q.bus8 & sb_s.address_bit_zero); // [R21] [R26]
   assign ack_start = cyc_act & ~cyc_prev_q & ~sb_s.ack_n;
   assign ret_start = cyc_act & ~cyc_prev_q & sb_s.ack_n;

   // priority 0 highest; in fixed mode in-service bits block lower priorities, and equal ones only when uncascaded, otherwise any in-service bit blocks all
   always_comb begin
      logic seen;
      seen = 1'b0;
      blocked = '0;
      win_vld = 1'b0;
      win_pos = 4'h0;
      ret_vld = 1'b0;
      ret_pos = 4'h0;
      for (int i = 0; i < NPOS; i++) begin
         if (ctrl_q.fixed) begin
            blocked[i] = seen | (in_service_bits_q[i] & ~cascade_source_list_q[i]); // [R25]
         end else begin
            blocked[i] = |in_service_bits_q;
         end
         seen = seen | in_service_bits_q[i];
      end
      for (int i = NPOS - 1; i >= 0; i--) begin
         if (pending_bits_q[i] & ~mask_q[i] & ~blocked[i]) begin
            win_vld = 1'b1;
            win_pos = 4'(i);
         end
         if (in_service_bits_q[i]) begin
            ret_vld = 1'b1;
            ret_pos = 4'(i);
         end
      end
   end

   // cascaded positions answer with a negative cascade table index
   // sixteen positions, each may carry a cascaded controller
   assign ack_byte = cascade_source_list_q[win_pos] ? {vcia_pkg::CASC_IDX_HI, win_pos}
                     : {vbase_q[7:4], win_pos}; // [R05] [R10] [R11] [R17] [R18]
   assign ret_byte = cascade_source_list_q[ret_pos] ? {vcia_pkg::CASC_IDX_HI, ret_pos}
                     : {vbase_q[7:4], ret_pos}; // [R19] [R20]
   assign ret_keep = cascade_source_list_q[ret_pos] && isc_cnt_q[ret_pos] > 4'h1;

   always_ff @(posedge i_sys_clk) begin
      if (rst_all) begin
         cyc_prev_q <= 1'b0;
      end else begin
         cyc_prev_q <= cyc_act;
      end
   end

   // request line: silent until software sets the enable bit
   always_ff @(posedge i_sys_clk) begin
      if (rst_all) begin
         o_int_n_q <= 1'b1; // [R02]
      end else begin
         o_int_n_q <= ~(ctrl_q.en & win_vld); // [R04] [R08]
      end
   end

   // data byte is latched at the start of the cycle and held until it ends
   always_ff @(posedge i_sys_clk) begin
      if (rst_all) begin
         sb_data_q <= 8'h00;
         sb_oe_n_q <= 1'b1;
      end else begin
         sb_oe_n_q <= ~cyc_act; // [R26]
         if (ack_start) begin
            sb_data_q <= ack_byte; // [R07]
         end else if (ret_start) begin
            sb_data_q <= ret_byte; // [R19]
         end
      end
   end

   // hardware set wins over software or acknowledge clear
   always_comb begin
      pending_bits_d = pending_bits_q;
      if (wr_fire && i_axi_awaddr == vcia_pkg::OFS_PEND) begin
         pending_bits_d = merge16(pending_bits_q, i_axi_wdata[15:0], i_axi_wstrb[1:0]);
      end
      if (ack_start && win_vld) begin
         pending_bits_d[win_pos] = 1'b0; // [R22]
      end
      if (ctrl_q.en) begin
         pending_bits_d = pending_bits_d | irq_s;
      end
   end

   always_comb begin
      in_service_bits_d = in_service_bits_q;
      if (ret_start && ret_vld && !ret_keep) begin
         in_service_bits_d[ret_pos] = 1'b0; // [R08] [R24]
      end
      if (ack_start && win_vld) begin
         in_service_bits_d[win_pos] = 1'b1; // [R22]
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (rst_all) begin
         pending_bits_q <= vcia_pkg::RST_PEND;
         in_service_bits_q <= '0;
         last_ack_q <= 4'h0;
      end else begin
         pending_bits_q <= pending_bits_d;
         in_service_bits_q <= in_service_bits_d;
         if (ack_start && win_vld) begin
            last_ack_q <= win_pos;
         end
      end
   end

   // one hidden in-service counter per position
   generate
      for (genvar g = 0; g < NPOS; g++) begin : g_isc
         always_ff @(posedge i_sys_clk) begin
            if (rst_all) begin
               isc_cnt_q[g] <= 4'h0;
            end else if (ack_start && win_vld && win_pos == 4'(g)
                         && ctrl_q.fixed && cascade_source_list_q[g]) begin
               isc_cnt_q[g] <= isc_cnt_q[g] + 4'h1; // [R16] [R23]
            end else if (ret_start && ret_vld && ret_pos == 4'(g)
                         && isc_cnt_q[g] != 4'h0) begin
               isc_cnt_q[g] <= isc_cnt_q[g] - 4'h1; // [R24]
            end
         end
      end
   endgenerate

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                           input logic [1:0] strb);
      merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
   endfunction : merge16

   // write: address and data are taken together, one write outstanding
   assign wr_fire = aw_ready_q;

   always_ff @(posedge i_sys_clk) begin
      if (rst_all) begin
         aw_ready_q <= 1'b0;
         w_ready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= vcia_pkg::RESP_OKAY;
      end else begin
         aw_ready_q <= i_axi_awvalid & i_axi_wvalid & ~aw_ready_q & ~bvalid_q;
         w_ready_q <= i_axi_awvalid & i_axi_wvalid & ~aw_ready_q & ~bvalid_q;
         if (aw_ready_q) begin
            bvalid_q <= 1'b1;
            bresp_q <= (i_axi_awaddr <= vcia_pkg::OFS_PEND && i_axi_awaddr[1:0] == 2'h0)
                       ? vcia_pkg::RESP_OKAY : vcia_pkg::RESP_SLVERR;
         end else if (i_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (rst_all) begin
         ctrl_q <= vcia_pkg::vcia_ctrl_t'(vcia_pkg::RST_CTRL);
         vbase_q <= vcia_pkg::RST_VBASE;
         cascade_source_list_q <= vcia_pkg::RST_CASC;
         mask_q <= vcia_pkg::RST_MASK;
      end else if (wr_fire) begin
         unique case (i_axi_awaddr)
            vcia_pkg::OFS_CTRL: begin
               if (i_axi_wstrb[0]) begin
                  ctrl_q <= vcia_pkg::vcia_ctrl_t'(i_axi_wdata[2:0]); // [R02]
               end
            end
            vcia_pkg::OFS_VBASE: begin
               if (i_axi_wstrb[0]) begin
                  vbase_q <= i_axi_wdata[7:0];
               end
            end
            vcia_pkg::OFS_CASC: begin
               cascade_source_list_q <= merge16(cascade_source_list_q, i_axi_wdata[15:0],
                                                i_axi_wstrb[1:0]); // [R15]
            end
            vcia_pkg::OFS_MASK: begin
               mask_q <= merge16(mask_q, i_axi_wdata[15:0], i_axi_wstrb[1:0]);
            end
            default: begin
            end
         endcase
      end
   end

   // read: one read outstanding, answered the cycle after arready
   always_ff @(posedge i_sys_clk) begin
      if (rst_all) begin
         ar_ready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= vcia_pkg::RESP_OKAY;
      end else begin
         ar_ready_q <= i_axi_arvalid & ~ar_ready_q & ~rvalid_q;
         if (ar_ready_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= vcia_pkg::RESP_OKAY;
            unique case (i_axi_araddr)
               vcia_pkg::OFS_CTRL: rdata_q <= {29'h0, ctrl_q};
               vcia_pkg::OFS_VBASE: rdata_q <= {24'h0, vbase_q};
               vcia_pkg::OFS_CASC: rdata_q <= {16'h0, cascade_source_list_q};
               vcia_pkg::OFS_MASK: rdata_q <= {16'h0, mask_q};
               vcia_pkg::OFS_PEND: rdata_q <= {16'h0, pending_bits_q};
               vcia_pkg::OFS_IN_SERVICE_BITS: rdata_q <= {16'h0, in_service_bits_q};
               vcia_pkg::OFS_STAT: rdata_q <= {20'h0, last_ack_q, win_pos, 3'h0, win_vld};
               default: begin
                  rdata_q <= 32'h0000_0000;
                  rresp_q <= vcia_pkg::RESP_SLVERR;
               end
            endcase
         end else if (i_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign o_int_n = o_int_n_q;
   assign o_sb_data = sb_data_q;
   assign o_sb_data_oe_n = sb_oe_n_q;
   assign o_axi_awready = aw_ready_q;
   assign o_axi_wready = w_ready_q;
   assign o_axi_bvalid = bvalid_q;
   assign o_axi_bresp = bresp_q;
   assign o_axi_arready = ar_ready_q;
   assign o_axi_rvalid = rvalid_q;
   assign o_axi_rdata = rdata_q;
   assign o_axi_rresp = rresp_q;

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (rst_all);

   sequence s_ack_taken;
      ack_start && win_vld;
   endsequence
   sequence s_ret_kept;
      ret_start && ret_vld && ret_keep;
   endsequence

   pin_reset_a: assert property (disable iff (i_reset) // [R01]
      !rst_pin_n_s |=> o_int_n && in_service_bits_q == '0)
      else $error("reset pin did not clear state");
   int_idle_a: assert property (!ctrl_q.en |=> o_int_n) // [R02]
      else $error("request raised while disabled");
   int_req_a: assert property (ctrl_q.en && win_vld |=> !o_int_n) // [R04]
      else $error("request not raised for unmasked winner");
   vec_low_a: assert property (s_ack_taken |=> o_sb_data[3:0] == $past(win_pos)) // [R05]
      else $error("vector low bits do not match position");
   casc_neg_a: assert property (s_ack_taken ##0 cascade_source_list_q[win_pos] // [R17]
      |=> o_sb_data[7])
      else $error("cascaded vector not negative");
   in_service_bits_set_a: assert property (s_ack_taken |=> in_service_bits_q[$past(win_pos)]) // [R22]
      else $error("in-service bit not set at acknowledge");
   cnt_inc_a: assert property (s_ack_taken ##0 // [R23]
      (ctrl_q.fixed && cascade_source_list_q[win_pos]) |=>
      isc_cnt_q[$past(win_pos)] == $past(isc_cnt_q[win_pos]) + 4'h1)
      else $error("in-service counter not incremented");
   in_service_bits_hold_a: assert property (s_ret_kept |=> in_service_bits_q[$past(ret_pos)]) // [R24]
      else $error("in-service bit cleared with nonzero counter");
   bus_drive_a: assert property (!o_sb_data_oe_n |-> $past(cyc_act)) // [R26]
      else $error("data bus driven outside a selected cycle");
   odd_addr_a: assert property (ctrl_q.bus8 && sb_s.address_bit_zero |=> o_sb_data_oe_n) // [R21]
      else $error("odd address answered in 8-bit mode");
endmodule : vcia_top

// ==== verif/vcia_cpu_model.sv ====
`timescale 1ns/1ps
module vcia_cpu_model (
   input wire logic i_sys_clk,
   input wire logic [7:0] i_sb_data,
   input wire logic i_sb_data_oe_n,
   output vcia_pkg::vcia_sbus_t o_sbus
);
   initial o_sbus = 5'h1E;

   // one strobe per cycle, ack or return, select only inside it
   task automatic bus_cycle(input bit ack, input bit a0, output logic [7:0] d, output bit seen);
      int n;
      seen = 0;
      d = 8'h00;
      @(posedge i_sys_clk);
      o_sbus <= {1'b0, 1'b0, !ack, ack, a0};
      for (n = 0; n < 8 && !seen; n++) begin
         @(negedge i_sys_clk);
         if (i_sb_data_oe_n === 1'b0) begin
            seen = 1;
            d = i_sb_data;
         end
      end
      @(posedge i_sys_clk);
      o_sbus <= 5'h1E;
      // idle gap so the next start is seen through the synchronisers
      repeat (5) @(posedge i_sys_clk);
   endtask : bus_cycle
endmodule : vcia_cpu_model

// ==== verif/vcia_tb_top.sv ====
`timescale 1ns/1ps
module vcia_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rpn = 1'b1;
   logic [15:0] irq = '0;
   vcia_pkg::vcia_sbus_t sbus;
   logic int_n, oe_n, awr, wrr, bv, arr, rv;
   logic [7:0] sbd;
   logic [4:0] awa = '0;
   logic [4:0] ara = '0;
   logic awv = 1'b0;
   logic wv = 1'b0;
   logic bre = 1'b0;
   logic arv = 1'b0;
   logic rre = 1'b0;
   logic [31:0] wd = '0;
   logic [3:0] ws = 4'hF;
   logic [31:0] rdat;
   logic [1:0] br, rr;
   int miscompares = 0;
   int tests_run = 0;
   int seed = 60;

   always #10 clk = ~clk;

   vcia_top u_dut (
      .i_sys_clk(clk), .i_reset(rst), .i_rst_pin_n(rpn), .i_irq(irq), .i_sbus(sbus),
      .o_int_n(int_n), .o_sb_data(sbd), .o_sb_data_oe_n(oe_n),
      .i_axi_awaddr(awa), .i_axi_awvalid(awv), .o_axi_awready(awr),
      .i_axi_wdata(wd), .i_axi_wstrb(ws), .i_axi_wvalid(wv), .o_axi_wready(wrr),
      .o_axi_bresp(br), .o_axi_bvalid(bv), .i_axi_bready(bre),
      .i_axi_araddr(ara), .i_axi_arvalid(arv), .o_axi_arready(arr),
      .o_axi_rdata(rdat), .o_axi_rresp(rr), .o_axi_rvalid(rv), .i_axi_rready(rre)
   );

   vcia_cpu_model u_cpu (.i_sys_clk(clk), .i_sb_data(sbd), .i_sb_data_oe_n(oe_n), .o_sbus(sbus));

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out

   task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_w

   task automatic chk_f(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t flag got %h exp %h", $time, got, exp);
      end
   endtask : chk_f

   task automatic lim();
      miscompares++;
      $display("BAD t=%0t wait ran out got %h exp %h", $time, 1'b0, 1'b1);
      close_out();
   endtask : lim

   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      bit ta, tw, got;
      ta = 0;
      tw = 0;
      got = 0;
      r = 2'h0;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      // ready is looked at mid-cycle, so the release edge is the edge that took it
      for (n = 0; n < 40 && !got; n++) begin
         @(negedge clk);
         ta = ta | (awr === 1'b1);
         tw = tw | (wrr === 1'b1);
         got = (bv === 1'b1);
         r = br;
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         if (got) bre <= 1'b0;
      end
      if (!got) lim();
   endtask : axi_wr

   task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      bit ta, got;
      ta = 0;
      got = 0;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      for (n = 0; n < 40 && !got; n++) begin
         @(negedge clk);
         ta = ta | (arr === 1'b1);
         got = (rv === 1'b1);
         d = rdat;
         r = rr;
         @(posedge clk);
         if (ta) arv <= 1'b0;
         if (got) rre <= 1'b0;
      end
      if (!got) lim();
   endtask : axi_rd

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk_w({30'h0, r}, {30'h0, vcia_pkg::RESP_OKAY});
   endtask : wr

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk_w({30'h0, r}, {30'h0, vcia_pkg::RESP_OKAY});
      chk_w(d, e);
   endtask : rd_chk

   task automatic cyc(input bit ack, input bit a0, input bit es, input logic [7:0] e);
      logic [7:0] d;
      bit s;
      u_cpu.bus_cycle(ack, a0, d, s);
      chk_f(s, es);
      if (es) chk_w({24'h0, d}, {24'h0, e});
      chk_f(oe_n, 1'b1);
   endtask : cyc

   task automatic wait_int(input logic e);
      int n;
      for (n = 0; n < 30 && int_n !== e; n++) @(negedge clk);
      chk_f(int_n, e);
      if (int_n !== e) close_out();
   endtask : wait_int

   // hold long enough to pass the input synchronisers, then let go
   task automatic pulse(input logic [15:0] m);
      @(posedge clk);
      irq <= m;
      repeat (6) @(posedge clk);
      irq <= '0;
   endtask : pulse

   function automatic logic [7:0] vec_of(input logic [7:0] vb, input logic [3:0] p, input bit c);
      return c ? {vcia_pkg::CASC_IDX_HI, p} : {vb[7:4], p};
   endfunction : vec_of

   initial begin
      logic [7:0] vb;
      logic [3:0] p;
      logic [31:0] d;
      logic [1:0] r;
      vb = 8'h00;
      repeat (20) @(posedge clk);
      chk_f(int_n, 1'b1);
      chk_f(oe_n, 1'b1);
      rst <= 1'b0;
      rd_chk(vcia_pkg::OFS_CTRL, 32'h0);
      rd_chk(vcia_pkg::OFS_CASC, 32'h0);
      rd_chk(vcia_pkg::OFS_MASK, 32'hFFFF);
      rd_chk(vcia_pkg::OFS_PEND, 32'h0);
      axi_rd(5'h1C, d, r);
      chk_w({30'h0, r}, {30'h0, vcia_pkg::RESP_SLVERR});
      axi_wr(vcia_pkg::OFS_IN_SERVICE_BITS, 32'hFFFF, r);
      chk_w({30'h0, r}, {30'h0, vcia_pkg::RESP_SLVERR});
      rd_chk(vcia_pkg::OFS_IN_SERVICE_BITS, 32'h0);
      $display("end of test reset");
      wr(vcia_pkg::OFS_MASK, 32'h0);
      pulse(16'h0004);
      repeat (10) @(posedge clk);
      chk_f(int_n, 1'b1);
      wr(vcia_pkg::OFS_CTRL, 32'h1);
      // a request seen while disabled is not latched, so raise it again
      pulse(16'h0004);
      wait_int(1'b0);
      cyc(1, 0, 1, vec_of(vb, 4'h2, 0));
      cyc(0, 0, 1, vec_of(vb, 4'h2, 0));
      $display("end of test enable");
      repeat (3) begin
         vb = 8'($random(seed)) & 8'h70;
         p = 4'($unsigned($random(seed)) % 14);
         wr(vcia_pkg::OFS_VBASE, {24'h0, vb});
         pulse((16'h1 << p) | 16'h8000);
         wait_int(1'b0);
         cyc(1, 0, 1, vec_of(vb, p, 0));
         rd_chk(vcia_pkg::OFS_PEND, 32'h8000);
         rd_chk(vcia_pkg::OFS_IN_SERVICE_BITS, 32'h1 << p);
         wait_int(1'b1);
         cyc(0, 0, 1, vec_of(vb, p, 0));
         wait_int(1'b0);
         cyc(1, 0, 1, vec_of(vb, 4'hF, 0));
         cyc(0, 0, 1, vec_of(vb, 4'hF, 0));
         rd_chk(vcia_pkg::OFS_IN_SERVICE_BITS, 32'h0);
      end
      $display("end of test priority");
      p = 4'($unsigned($random(seed)) % 14) + 4'h1;
      wr(vcia_pkg::OFS_CTRL, 32'h3);
      wr(vcia_pkg::OFS_CASC, 32'h1 << p);
      repeat (2) begin
         pulse(16'h1 << p);
         wait_int(1'b0);
         cyc(1, 0, 1, vec_of(vb, p, 1));
      end
      rd_chk(vcia_pkg::OFS_CASC, 32'h1 << p);
      rd_chk(vcia_pkg::OFS_IN_SERVICE_BITS, 32'h1 << p);
      cyc(0, 0, 1, vec_of(vb, p, 1));
      rd_chk(vcia_pkg::OFS_IN_SERVICE_BITS, 32'h1 << p);
      cyc(0, 0, 1, vec_of(vb, p, 1));
      rd_chk(vcia_pkg::OFS_IN_SERVICE_BITS, 32'h0);
      $display("end of test cascade");
      wr(vcia_pkg::OFS_CTRL, 32'h5);
      wr(vcia_pkg::OFS_CASC, 32'h0);
      pulse(16'h0002);
      wait_int(1'b0);
      cyc(1, 1, 0, 8'h00);
      rd_chk(vcia_pkg::OFS_PEND, 32'h2);
      rd_chk(vcia_pkg::OFS_STAT, {20'h0, p, 8'h11});
      cyc(1, 0, 1, vec_of(vb, 4'h1, 0));
      cyc(0, 0, 1, vec_of(vb, 4'h1, 0));
      $display("end of test bus8");
      ws <= 4'h2;
      wr(vcia_pkg::OFS_MASK, 32'hFFFF);
      ws <= 4'hF;
      rd_chk(vcia_pkg::OFS_MASK, 32'hFF00);
      wr(vcia_pkg::OFS_MASK, 32'h1234);
      @(posedge clk);
      rpn <= 1'b0;
      repeat (4) @(posedge clk);
      rpn <= 1'b1;
      repeat (5) @(posedge clk);
      rd_chk(vcia_pkg::OFS_MASK, 32'hFFFF);
      rd_chk(vcia_pkg::OFS_CTRL, 32'h0);
      chk_f(int_n, 1'b1);
      $display("end of test reset pin");
      close_out();
   end
endmodule : vcia_tb_top
